/* bfx_regs.vh */
// Opcode encodings and field constants for the bitfield and extend datapath
`ifndef BFX_REGS_VH
`define BFX_REGS_VH

// Operation select codes
`define BFX_OP_W 4
`define BFX_OP_FIELD_CLEAR 4'h0
`define BFX_OP_FIELD_INSERT 4'h1
`define BFX_OP_SIGNED_FIELD_EXTRACT 4'h2
`define BFX_OP_UNSIGNED_FIELD_EXTRACT 4'h3
`define BFX_OP_SIGNED_BYTE_EXTEND 4'h4
`define BFX_OP_SIGNED_HALF_EXTEND 4'h5
`define BFX_OP_UNSIGNED_BYTE_EXTEND 4'h6
`define BFX_OP_UNSIGNED_HALF_EXTEND 4'h7

// Rotation select codes
`define BFX_ROT_W 2
`define BFX_ROT_NONE 2'h0
`define BFX_ROT_8 2'h1
`define BFX_ROT_16 2'h2
`define BFX_ROT_24 2'h3

// Field geometry
`define BFX_DATA_W 32
`define BFX_LSB_W 5
`define BFX_WIDTH_W 6
`define BFX_LSB_MAX 5'h1F
`define BFX_WIDTH_MIN 6'h01
`define BFX_WIDTH_LIMIT 6'h20
`define BFX_BYTE_MSB 6'h07
`define BFX_HALF_MSB 6'h0F

// Reset value of the result registers
`define BFX_RESULT_RST 32'h00000000

`endif

/* bfx_datapath.v */
// Bitfield clear/insert/extract and byte/halfword extend datapath, one cycle
//Function
// - Field clear zeroes width bits from lsb
// - Field insert copies source low bits into field
// - Low bit position accepted only 0 to 31
// - Width 1 to 32 minus lsb only
// - Signed extract sign-extends field to 32 bits
// - Unsigned extract zero-extends field to 32 bits
// - Size selects byte or halfword input
// - Rotate right 0, 8, 16, 24 first
// - Byte forms use bits 7:0
// - Halfword forms use bits 15:0
// - Condition flags never altered
`timescale 1ns/1ps
`include "bfx_regs.vh"

module bfx_datapath #(
   parameter DATA_W = `BFX_DATA_W
) (
   // Clock and reset
   input wire MCLK_I,
   input wire RESET_N_I,
   // Issue from decoder
   input wire ISSUE_VALID_I,
   input wire [`BFX_OP_W-1:0] OP_SEL_I,
   input wire COND_PASS_I,
   input wire [31:0] DEST_OLD_I,
   input wire [31:0] SOURCE_REG_I,
   input wire [31:0] OPERAND_REG_I,
   input wire [`BFX_LSB_W-1:0] LSB_I,
   input wire [`BFX_WIDTH_W-1:0] WIDTH_I,
   input wire [`BFX_ROT_W-1:0] ROT_SEL_I,
   input wire [3:0] FLAGS_NZCV_I,
   input wire FLAG_Q_I,
   // Result to register file
   output reg RESULT_VALID_O,
   output reg WRITE_EN_O,
   output reg [31:0] RESULT_O,
   output reg OPERAND_ERR_O,
   output reg [3:0] FLAGS_NZCV_O,
   output reg FLAG_Q_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Mask of width ones starting at bit lsb
   function [31:0] bfx_field_mask;
      input [`BFX_LSB_W-1:0] lsb;
      input [`BFX_WIDTH_W-1:0] width;
      reg [32:0] ones;
      begin
         ones = ({1'b0, 32'h00000000} | 33'h000000001) << width;
         ones = ones - 33'h000000001;
         bfx_field_mask = ones[31:0] << lsb;
      end
   endfunction

   // Replicate a chosen sign bit above position msb
   function [31:0] bfx_extend;
      input [31:0] val;
      input [5:0] msb;
      input is_signed;
      integer k;
      begin
         bfx_extend = 32'h00000000;
         for (k = 0; k < 32; k = k + 1) begin
            if (k <= msb) begin
               bfx_extend[k] = val[k];
            end else begin
               bfx_extend[k] = is_signed & val[msb[4:0]];
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   wire lsb_ok;
   wire width_ok;
   wire [6:0] width_sum;
   wire [31:0] mask;
   wire [31:0] field_shifted;
   wire [5:0] field_msb;
   reg [31:0] rotated;
   reg [31:0] result_nxt;
   reg op_known;

   // Out-of-range geometry is flagged and never written back
   assign lsb_ok = ({1'b0, LSB_I} <= {1'b0, `BFX_LSB_MAX});
   assign width_sum = {2'b00, LSB_I} + {1'b0, WIDTH_I};
   assign width_ok = (WIDTH_I >= `BFX_WIDTH_MIN) && (width_sum <= {1'b0, `BFX_WIDTH_LIMIT});
   assign mask = bfx_field_mask(LSB_I, WIDTH_I);
   assign field_shifted = SOURCE_REG_I >> LSB_I;
   assign field_msb = WIDTH_I - 6'h01;

   // Rotation ahead of byte and halfword extends
   always @* begin
      case (ROT_SEL_I)
         `BFX_ROT_8: rotated = {OPERAND_REG_I[7:0], OPERAND_REG_I[31:8]};
         `BFX_ROT_16: rotated = {OPERAND_REG_I[15:0], OPERAND_REG_I[31:16]};
         `BFX_ROT_24: rotated = {OPERAND_REG_I[23:0], OPERAND_REG_I[31:24]};
         default: rotated = OPERAND_REG_I;
      endcase
   end

   always @* begin
      result_nxt = DEST_OLD_I;
      op_known = 1'b1;
      case (OP_SEL_I)
         `BFX_OP_FIELD_CLEAR: result_nxt = DEST_OLD_I & ~mask;
         `BFX_OP_FIELD_INSERT: result_nxt = (DEST_OLD_I & ~mask) | ((SOURCE_REG_I << LSB_I) & mask);
         `BFX_OP_SIGNED_FIELD_EXTRACT: result_nxt = bfx_extend(field_shifted, field_msb, 1'b1);
         `BFX_OP_UNSIGNED_FIELD_EXTRACT: result_nxt = bfx_extend(field_shifted, field_msb, 1'b0);
         `BFX_OP_SIGNED_BYTE_EXTEND: result_nxt = bfx_extend(rotated, `BFX_BYTE_MSB, 1'b1);
         `BFX_OP_UNSIGNED_BYTE_EXTEND: result_nxt = bfx_extend(rotated, `BFX_BYTE_MSB, 1'b0);
         `BFX_OP_SIGNED_HALF_EXTEND: result_nxt = bfx_extend(rotated, `BFX_HALF_MSB, 1'b1);
         `BFX_OP_UNSIGNED_HALF_EXTEND: result_nxt = bfx_extend(rotated, `BFX_HALF_MSB, 1'b0);
         default: op_known = 1'b0;
      endcase
   end

   // Extends ignore lsb and width, so only field ops check geometry
   wire is_field_op;
   wire geom_bad;
   assign is_field_op = (OP_SEL_I <= `BFX_OP_UNSIGNED_FIELD_EXTRACT);
   assign geom_bad = !op_known || (is_field_op && !(lsb_ok && width_ok));

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         RESULT_VALID_O <= 1'b0;
         WRITE_EN_O <= 1'b0;
         RESULT_O <= `BFX_RESULT_RST;
         OPERAND_ERR_O <= 1'b0;
         FLAGS_NZCV_O <= 4'h0;
         FLAG_Q_O <= 1'b0;
      end else begin
         RESULT_VALID_O <= ISSUE_VALID_I;
         WRITE_EN_O <= ISSUE_VALID_I && COND_PASS_I && !geom_bad;
         OPERAND_ERR_O <= ISSUE_VALID_I && geom_bad;
         // Old destination on suppression keeps the port stable
         RESULT_O <= (COND_PASS_I && !geom_bad) ? result_nxt : DEST_OLD_I;
         FLAGS_NZCV_O <= FLAGS_NZCV_I;
         FLAG_Q_O <= FLAG_Q_I;
      end
   end

endmodule // bfx_datapath

/* bfx_dp_monitor.sv */
// Port checker for the bitfield datapath
`timescale 1ns/1ps
module bfx_dp_monitor (
   // Inputs and outputs of the datapath
   input wire MCLK_I, RESET_N_I, ISSUE_VALID_I, COND_PASS_I, WRITE_EN_O, OPERAND_ERR_O,
   input wire [3:0] OP_SEL_I, FLAGS_NZCV_I, FLAGS_NZCV_O,
   input wire [4:0] LSB_I,
   input wire [5:0] WIDTH_I,
   input wire [31:0] DEST_OLD_I, RESULT_O
);
default clocking @(posedge MCLK_I); endclocking
default disable iff (!RESET_N_I);
// Seven bits so that lsb plus width cannot wrap
wire bad = WIDTH_I == 0 || LSB_I + WIDTH_I + 7'h0 > 32;
wire ok = ISSUE_VALID_I & COND_PASS_I;
property p_fl; 1 |=> FLAGS_NZCV_O == $past(FLAGS_NZCV_I); endproperty
a_fl: assert property (p_fl) else $error("flags");
property p_nc; ISSUE_VALID_I && !COND_PASS_I |=> !WRITE_EN_O && RESULT_O == $past(DEST_OLD_I); endproperty
a_nc: assert property (p_nc) else $error("cond");
property p_ge; ISSUE_VALID_I && OP_SEL_I < 4 && bad |=> OPERAND_ERR_O && !WRITE_EN_O; endproperty
a_ge: assert property (p_ge) else $error("geometry");
property p_ex; ok && OP_SEL_I[3:2] == 1 |=> WRITE_EN_O && !OPERAND_ERR_O; endproperty
a_ex: assert property (p_ex) else $error("extend");
property p_ub; ok && OP_SEL_I == 6 |=> RESULT_O[31:8] == 0; endproperty
a_ub: assert property (p_ub) else $error("ubyte");
property p_sb; ok && OP_SEL_I == 4 |=> RESULT_O[31:8] == {24{RESULT_O[7]}}; endproperty
a_sb: assert property (p_sb) else $error("sbyte");
property p_uh; ok && OP_SEL_I == 7 |=> RESULT_O[31:16] == 0; endproperty
a_uh: assert property (p_uh) else $error("uhalf");
property p_ux; ok && OP_SEL_I == 3 && !bad |=> (RESULT_O >> $past(WIDTH_I)) == 0; endproperty
a_ux: assert property (p_ux) else $error("uextract");
cover property (ok && OP_SEL_I == 1);
cover property (OPERAND_ERR_O);
cover property (ISSUE_VALID_I && !COND_PASS_I);
endmodule // bfx_dp_monitor

/* bfx_dec_model.sv */
// Decoder and register file model issuing one operation per cycle
`timescale 1ns/1ps
module bfx_dec_model (
   input wire clk_i,
   output reg v_o, c_o,
   output reg [3:0] op_o,
   output reg [4:0] l_o,
   output reg [5:0] w_o,
   output reg [1:0] r_o,
   output reg [31:0] d_o
);
initial {v_o, c_o, op_o, l_o, w_o, r_o, d_o} = 0;
// Entered 1 ns after an edge; valid stays up so calls run back to back
task go(input v, c, input [3:0] op, input [4:0] l, input [5:0] w, input [1:0] r, input [31:0] d);
   {v_o, c_o, op_o, l_o, w_o, r_o, d_o} = {v, c, op, l, w, r, d};
   @(posedge clk_i);
   #1;
endtask
endmodule // bfx_dec_model

/* bitfield_extend_datapath_test.sv */
// Self-checking bench for the bitfield datapath
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module bitfield_extend_datapath_test;
reg clk = 0, rst_n = 0;
int errors = 0, cmp_count = 0;
wire v, c, rv, we, er, qo;
wire [3:0] op, fo;
wire [4:0] l;
wire [5:0] w;
wire [1:0] r;
wire [31:0] d, res;
initial forever #2.5 clk = ~clk;
bfx_dec_model dec(.clk_i(clk), .v_o(v), .c_o(c), .op_o(op), .l_o(l), .w_o(w), .r_o(r), .d_o(d));
bfx_datapath uut(.MCLK_I(clk), .RESET_N_I(rst_n), .ISSUE_VALID_I(v), .OP_SEL_I(op), .COND_PASS_I(c),
   .DEST_OLD_I(d), .SOURCE_REG_I(~d), .OPERAND_REG_I(d), .LSB_I(l), .WIDTH_I(w), .ROT_SEL_I(r),
   .FLAGS_NZCV_I(d[4:1]), .FLAG_Q_I(d[0]), .RESULT_VALID_O(rv), .WRITE_EN_O(we), .RESULT_O(res),
   .OPERAND_ERR_O(er), .FLAGS_NZCV_O(fo), .FLAG_Q_O(qo));
task run(input c1, input [3:0] k, input [4:0] a, input [5:0] b, input [1:0] r2, input [31:0] dd);
   logic [63:0] lm, fm, x;
   logic [31:0] e;
   logic lg;
   lm = (64'h1 << b) - 1;
   fm = lm << a;
   x = {dd, dd} >> (8 * r2);
   lg = k < 4 ? b != 0 && a + b <= 32 : k < 8;
   case (k)
      0: e = dd & ~fm[31:0];
      1: e = dd & ~fm[31:0] | ~dd << a & fm[31:0];
      2, 3: e = ~dd >> a & lm[31:0];
      4: e = {{24{x[7]}}, x[7:0]};
      5: e = {{16{x[15]}}, x[15:0]};
      6: e = {24'h0, x[7:0]};
      default: e = {16'h0, x[15:0]};
   endcase
   if (k == 2) e = ~dd >> a & lm[31:0] | (b != 0 && ~dd[a + b - 1] ? ~lm[31:0] : 32'h0);
   dec.go(1, c1, k, a, b, r2, dd);
   `CHK(rv, 1'b1)
   `CHK(we, c1 & lg)
   `CHK(er, !lg)
   `CHK(res, c1 & lg ? e : dd)
   `CHK({fo, qo}, dd[4:0])
endtask
task t_field;
   for (int k = 0; k < 4; k++) begin
      run(1, k, 8, 12, 0, 32'h5A5AC3C3);
      run(1, k, 0, 32, 0, 32'h3C0F5A96);
      run(1, k, 31, 1, 0, 32'h0000FFFF);
      run(1, k, 20, 4, 0, 32'hFF0F0000);
   end
endtask
task t_ext;
   for (int k = 4; k < 8; k++)
      for (int j = 0; j < 4; j++)
         run(1, k, 0, 0, j, 32'h80F27F34);
endtask
task t_refuse;
   run(0, 1, 8, 12, 0, 32'h13579BDF);
   run(1, 0, 4, 0, 0, 32'h2468ACE0);
   run(1, 3, 31, 2, 0, 32'h11112222);
   run(1, 9, 0, 8, 0, 32'h33334444);
   dec.go(0, 1, 0, 0, 1, 0, 0);
   `CHK(rv, 1'b0)
endtask
task report_and_stop;
   $display("errors=%0d compares=%0d", errors, cmp_count);
   if (errors == 0 && cmp_count > 0) $display("TB: PASS");
   else $display("TB: FAIL");
   $finish;
endtask
initial begin
   repeat (12) @(posedge clk);
   #1 rst_n = 1;
   @(posedge clk);
   #1;
   t_field;
   t_ext;
   t_refuse;
   report_and_stop;
end
initial begin
   #5000;
   errors++;
   report_and_stop;
end
endmodule // bitfield_extend_datapath_test
bind bfx_datapath bfx_dp_monitor mon(.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .ISSUE_VALID_I(ISSUE_VALID_I),
   .COND_PASS_I(COND_PASS_I), .WRITE_EN_O(WRITE_EN_O), .OPERAND_ERR_O(OPERAND_ERR_O), .OP_SEL_I(OP_SEL_I),
   .FLAGS_NZCV_I(FLAGS_NZCV_I), .FLAGS_NZCV_O(FLAGS_NZCV_O), .LSB_I(LSB_I), .WIDTH_I(WIDTH_I),
   .DEST_OLD_I(DEST_OLD_I), .RESULT_O(RESULT_O));
